// ---- scu_sensor_config_uart_command.sv ----
// command interpreter: 8N1 uart, config memory, ram, mode decode, clock trim
// assumes rx pin already synchronous; config memory contents survive soft reset
`default_nettype none
module scu_sensor_config_uart_command
   import scu_pkg::*;
#(
   parameter int BAUD = BAUD_DEFAULT,
   parameter int CLK_HZ = CORE_CLK_HZ
)(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // serial link
   input wire logic serialRx,
   output logic serialTx,
   // measurement inputs
   input wire logic [9:0] temperatureReading,
   input wire logic [15:0] sampledInput,
   // configuration outputs
   output logic [7:0] operating_mode_config,
   output logic [7:0] oscillatorTrim,
   output logic checksumFault,
   output logic [11:0] faultValue,
   output logic digital_output_override,
   output logic [7:0] overrideLevel,
   output logic loopFixedActive,
   output logic [11:0] loopFixedValue,
   // general pins, low enable means driven; then active-high mode output enables
   input wire logic general_pin_one_in,
   input wire logic general_pin_two_in,
   output logic general_pin_one_out,
   output logic general_pin_two_out,
   output logic general_pin_one_oe_n,
   output logic general_pin_two_oe_n,
   output logic voltage_output_enable,
   output logic current_loop_output_enable,
   output logic turboEnable,
   output logic externalTempSelect
);
   // -------------------------------------------------------------
   // baud timing
   // -------------------------------------------------------------
   localparam int BIT_CYC = CLK_HZ / BAUD;
   localparam int CW = $clog2(BIT_CYC + 1);
   localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
   localparam logic [CW-1:0] HALF_BIT = CW'(BIT_CYC / 2);

   logic [7:0] cfgMem [0:CFG_BYTES-1];
   logic [7:0] ramMem [0:RAM_BYTES-1];

   // -------------------------------------------------------------
   // receiver, 8N1
   // -------------------------------------------------------------
   logic [CW-1:0] rxCnt_reg;
   logic [3:0] rxBit_reg;
   logic [7:0] rxShift_reg;
   logic rxBusy_reg;
   logic rxValid_reg;
   wire rxTick = rxBusy_reg && (rxCnt_reg == '0);
   wire rxStart = !rxBusy_reg && !serialRx;
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rxBusy_reg <= 1'b0;
         rxCnt_reg <= '0;
         rxBit_reg <= 4'h0;
         rxShift_reg <= 8'h00;
         rxValid_reg <= 1'b0;
      end
      else
      begin
         rxValid_reg <= 1'b0;
         if (rxStart)
         begin
            rxBusy_reg <= 1'b1;
            rxCnt_reg <= HALF_BIT;
            rxBit_reg <= 4'h0;
         end
         else if (rxTick)
         begin
            rxCnt_reg <= BIT_LAST;
            rxBit_reg <= rxBit_reg + 4'h1;
            if (rxBit_reg >= 4'h1 && rxBit_reg <= 4'h8)
               rxShift_reg <= {serialRx, rxShift_reg[7:1]};
            if (rxBit_reg == 4'h9)
            begin
               rxBusy_reg <= 1'b0;
               rxValid_reg <= serialRx; // [RL23]
            end
            if (rxBit_reg == 4'h0 && serialRx)
               rxBusy_reg <= 1'b0;
         end
         else if (rxBusy_reg)
            rxCnt_reg <= rxCnt_reg - CW'(1);
      end
   end

   // -------------------------------------------------------------
   // transmitter, 8N1
   // -------------------------------------------------------------
   logic [CW-1:0] txCnt_reg;
   logic [3:0] txBit_reg;
   logic [9:0] txShift_reg;
   logic txBusy_reg;
   logic txGo;
   logic [7:0] txByte;
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         txBusy_reg <= 1'b0;
         txCnt_reg <= '0;
         txBit_reg <= 4'h0;
         txShift_reg <= 10'h3FF;
      end
      else if (txGo)
      begin
         txBusy_reg <= 1'b1;
         txShift_reg <= {1'b1, txByte, 1'b0}; // [RL23]
         txCnt_reg <= BIT_LAST;
         txBit_reg <= 4'h0;
      end
      else if (txBusy_reg)
      begin
         if (txCnt_reg == '0)
         begin
            txCnt_reg <= BIT_LAST;
            txShift_reg <= {1'b1, txShift_reg[9:1]};
            txBit_reg <= txBit_reg + 4'h1;
            if (txBit_reg == 4'h9)
               txBusy_reg <= 1'b0;
         end
         else
            txCnt_reg <= txCnt_reg - CW'(1);
      end
   end
   assign serialTx = txShift_reg[0];

   // -------------------------------------------------------------
   // command sequencer
   // -------------------------------------------------------------
   scu_state_t state_reg;
   logic [5:0] idx_reg;
   logic [7:0] sum_reg;
   logic [7:0] cmd_reg;
   logic [7:0] out_reg;
   logic [1:0] acksLeft_reg;
   logic resetAfter_reg;
   logic storeOk_reg;
   logic softReset_reg;
   wire [1:0] cmdOp = rxShift_reg[7:6]; // [RL1]
   wire [5:0] cmdAddr = rxShift_reg[5:0];
   wire cfgAddrOk = cmdAddr <= CFG_LAST; // [RL3]
   wire isReadRam = cmdOp == OP_RAM_RD; // [RL2]
   wire isReadCfg = cmdOp == OP_CFG_RD;
   wire isWrite = (cmdOp == OP_CFG_WR && cfgAddrOk) || cmdOp == OP_RAM_WR;
   wire isResetCmd = isReadCfg && cmdAddr == CFG_RESET_ADDR; // [RL3]
   wire wrCfg = cmd_reg[7:6] == OP_CFG_WR;
   assign txGo = state_reg == ST_SEND && !txBusy_reg;
   assign txByte = out_reg;

   always_ff @(posedge core_clk)
   begin
      if (softReset_reg)
         softReset_reg <= 1'b0;
      if (reset || softReset_reg)
      begin
         state_reg <= ST_INIT;
         idx_reg <= 6'h00;
         sum_reg <= 8'h00;
         cmd_reg <= 8'h00;
         out_reg <= 8'h00;
         acksLeft_reg <= 2'h0;
         resetAfter_reg <= 1'b0;
         storeOk_reg <= 1'b0;
         if (reset)
            softReset_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_INIT:
            begin
               idx_reg <= 6'h00;
               sum_reg <= 8'h00;
               state_reg <= ST_SUM;
            end
            ST_SUM:
            begin
               sum_reg <= sum_reg + cfgMem[idx_reg]; // [RL13]
               idx_reg <= idx_reg + 6'h01;
               if (idx_reg == CFG_LAST)
                  state_reg <= ST_LOAD;
            end
            ST_LOAD:
               state_reg <= ST_IDLE;
            ST_IDLE:
               if (rxValid_reg)
               begin
                  cmd_reg <= rxShift_reg;
                  resetAfter_reg <= 1'b0;
                  acksLeft_reg <= 2'h0;
                  if (isResetCmd)
                  begin
                     out_reg <= ACK_BYTE; // [RL8]
                     resetAfter_reg <= 1'b1;
                     state_reg <= ST_SEND;
                  end
                  else if (isReadRam)
                  begin
                     out_reg <= ramMem[cmdAddr]; // [RL4]
                     state_reg <= ST_SEND;
                  end
                  else if (isReadCfg && cfgAddrOk)
                  begin
                     out_reg <= cfgMem[cmdAddr]; // [RL4]
                     state_reg <= ST_SEND;
                  end
                  else if (isWrite)
                  begin
                     out_reg <= rxShift_reg; // [RL5]
                     state_reg <= ST_SEND;
                  end
               end
            ST_SEND:
               if (!txBusy_reg)
                  state_reg <= ST_WAIT_TX;
            ST_WAIT_TX:
               if (!txBusy_reg)
               begin
                  if (resetAfter_reg)
                     state_reg <= ST_RESET;
                  else if (acksLeft_reg != 2'h0)
                  begin
                     acksLeft_reg <= acksLeft_reg - 2'h1;
                     state_reg <= ST_SEND; // [RL6]
                  end
                  else if (!storeOk_reg && (cmd_reg[7:6] == OP_CFG_WR || cmd_reg[7:6] == OP_RAM_WR))
                     state_reg <= ST_WAIT_DATA; // [RL7]
                  else
                  begin
                     storeOk_reg <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
               end
            ST_WAIT_DATA:
               if (rxValid_reg)
                  state_reg <= ST_STORE;
            ST_STORE:
            begin
               out_reg <= ACK_BYTE; // [RL6]
               acksLeft_reg <= 2'h1;
               storeOk_reg <= 1'b1;
               state_reg <= ST_SEND;
            end
            ST_RESET:
               softReset_reg <= 1'b1; // [RL8]
         endcase
      end
   end

   // memory writes; config survives soft reset, ram is cleared at init
   wire storeNow = state_reg == ST_STORE;
   always_ff @(posedge core_clk)
   begin
      // model starts blank at power-up, so the first load sees no unknowns
      if (reset)
         cfgMem <= '{default: 8'h00};
      else if (storeNow && wrCfg)
         cfgMem[cmd_reg[5:0]] <= rxShift_reg;
      // two halves overlap so all 64 ram bytes clear in 48 sum cycles
      if (state_reg == ST_SUM)
      begin
         ramMem[idx_reg] <= 8'h00;
         ramMem[idx_reg + 6'h10] <= 8'h00;
      end
      else if (storeNow && !wrCfg)
         ramMem[cmd_reg[5:0]] <= rxShift_reg;
      else if (state_reg == ST_IDLE)
      begin
         // measurements kept as full 16-bit words
         ramMem[6'h3A] <= {temperatureReading[9:2]}; // [RL22]
         ramMem[6'h3B] <= {temperatureReading[1:0], 6'h00};
         ramMem[6'h3C] <= sampledInput[15:8];
         ramMem[6'h3D] <= sampledInput[7:0];
      end
   end

   // -------------------------------------------------------------
   // shadow configuration latched at init, then range trim driven onto oscillatorTrim
   // -------------------------------------------------------------
   logic [7:0] trimLow_reg, trimHigh_reg, trimA_reg, trimB_reg, trimC_reg;
   logic [7:0] lowTrig_reg, lowOut_reg, highTrig_reg, highOut_reg;
   logic [7:0] lvl0_reg, lvl1_reg, lvl2_reg;
   logic bootDone_reg;
   logic [7:0] tempTrim;
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         operating_mode_config <= 8'h00;
         checksumFault <= 1'b0;
         faultValue <= 12'h000;
         loopFixedValue <= 12'h000;
         bootDone_reg <= 1'b0;
         oscillatorTrim <= 8'h00;
         {trimLow_reg, trimHigh_reg, trimA_reg, trimB_reg, trimC_reg} <= 40'h0;
         {lowTrig_reg, lowOut_reg, highTrig_reg, highOut_reg} <= 32'h0;
         {lvl0_reg, lvl1_reg, lvl2_reg} <= 24'h0;
      end
      else if (state_reg == ST_INIT)
      begin
         bootDone_reg <= 1'b0;
         oscillatorTrim <= cfgMem[CFG_BOOT_TRIM]; // [RL12]
      end
      else if (state_reg == ST_LOAD)
      begin
         operating_mode_config <= cfgMem[CFG_MODE]; // [RL9]
         checksumFault <= cfgMem[CFG_MODE][MODE_CHECK] && sum_reg != CHECKSUM_TARGET; // [RL14]
         faultValue <= {cfgMem[CFG_FAULT_HI][3:0], cfgMem[CFG_FAULT_LO]}; // [RL15]
         loopFixedValue <= {cfgMem[CFG_LOOP_FIXED_HI][3:0], cfgMem[CFG_LOOP_FIXED_LO]}; // [RL10]
         trimLow_reg <= cfgMem[CFG_CLOCK_THR_LOW];
         trimHigh_reg <= cfgMem[CFG_CLOCK_THR_HIGH];
         trimA_reg <= cfgMem[CFG_TRIM_A];
         trimB_reg <= cfgMem[CFG_TRIM_B];
         trimC_reg <= cfgMem[CFG_TRIM_C];
         lowTrig_reg <= cfgMem[CFG_ALARM_LOW_TRIG];
         lowOut_reg <= cfgMem[CFG_ALARM_LOW_OUT];
         highTrig_reg <= cfgMem[CFG_ALARM_HIGH_TRIG];
         highOut_reg <= cfgMem[CFG_ALARM_HIGH_OUT];
         lvl0_reg <= cfgMem[CFG_STEER_LVL0];
         lvl1_reg <= cfgMem[CFG_STEER_LVL1];
         lvl2_reg <= cfgMem[CFG_STEER_LVL2];
         bootDone_reg <= 1'b1;
      end
      else if (bootDone_reg)
         oscillatorTrim <= tempTrim; // [RL11]
   end

   // -------------------------------------------------------------
   // mode decode and temperature clock trim
   // -------------------------------------------------------------
   wire [7:0] tempHigh = temperatureReading[9:2];
   wire [7:0] inHigh = sampledInput[15:8];
   assign tempTrim = (tempHigh < trimLow_reg) ? trimA_reg :
      (tempHigh < trimHigh_reg) ? trimB_reg : trimC_reg; // [RL11]
   wire steerOn = operating_mode_config[MODE_STEER]; // [RL19]
   wire limitOn = operating_mode_config[MODE_LIMIT] && !steerOn; // [RL18]
   wire digitalOn = operating_mode_config[MODE_DIGITAL]; // [RL16]
   wire lowHit = limitOn && inHigh < lowTrig_reg;
   wire highHit = limitOn && inHigh > highTrig_reg;
   assign digital_output_override = lowHit || highHit; // [RL18]
   assign overrideLevel = lowHit ? lowOut_reg : (highHit ? highOut_reg : 8'h00);
   assign voltage_output_enable = operating_mode_config[MODE_VOUT]; // [RL20]
   assign current_loop_output_enable = operating_mode_config[MODE_LOOP];
   assign turboEnable = operating_mode_config[MODE_TURBO];
   assign externalTempSelect = operating_mode_config[MODE_EXT_TEMP];
   assign loopFixedActive = voltage_output_enable && current_loop_output_enable && digitalOn; // [RL21]
   assign general_pin_one_out = steerOn && (inHigh >= lvl0_reg) && (inHigh < lvl1_reg || inHigh >= lvl2_reg); // [RL19]
   assign general_pin_two_out = steerOn && inHigh >= lvl1_reg;
   assign general_pin_one_oe_n = !steerOn;
   assign general_pin_two_oe_n = !steerOn;
endmodule
`default_nettype wire

// ---- scu_pkg.sv ----
// constants and types for the serial configuration command interpreter
// assumes a single core clock and synchronous active-high reset
//
// Contract
// [RL1] one command byte: top two bits operation, low six bits byte address
// [RL2] operation 11 read ram, 10 read config, 01 write config, 00 write ram
// [RL3] ram addresses 0-63, config 0-47; config read of 63 means reset
// [RL4] read command returns addressed byte with no further host request
// [RL5] write command byte is echoed to signal readiness for data
// [RL6] stored write data acknowledged with two BCh bytes
// [RL7] host sends data after echo; missing acks mean write not done
// [RL8] config read of 63 sends one BCh then soft resets
// [RL9] config writes take effect only after soft reset reload
// [RL10] 12-bit variables: full low byte plus shared nibble byte
// [RL11] temperature classed in three ranges by thresholds, range trim applied
// [RL12] boot trim from config byte 1 applies before temperature trim
// [RL13] enabled checksum: 8-bit sum of config bytes equals 0FFh, byte 47 balances
// [RL14] checksum checked at ram init after reset; mismatch forces fault output
// [RL15] fault output value taken from config bytes 40 and 41
// [RL16] mode bit 7 checksum enable, bit 6 digital mode
// [RL17] configurer selects digital mode when both outputs enabled
// [RL18] mode bit 5 limiting to alarm levels, disabled under level steering
// [RL19] mode bit 4 general pins show two-bit level, else analog inputs
// [RL20] mode bits 3..0 turbo, voltage out, external sensor, current loop
// [RL21] both outputs plus digital: current loop holds fixed config value
// [RL22] ram coefficients packed 12-bit, measurements full 16-bit
// [RL23] serial bytes 8N1 at configured baud rate
`default_nettype none
package scu_pkg;
   localparam logic [1:0] OP_RAM_WR = 2'h0;
   localparam logic [1:0] OP_CFG_WR = 2'h1;
   localparam logic [1:0] OP_CFG_RD = 2'h2;
   localparam logic [1:0] OP_RAM_RD = 2'h3;
   localparam logic [5:0] CFG_LAST = 6'h2F;
   localparam logic [5:0] CFG_RESET_ADDR = 6'h3F;
   localparam logic [7:0] ACK_BYTE = 8'hBC;
   localparam logic [7:0] CHECKSUM_TARGET = 8'hFF;
   localparam logic [5:0] CFG_MODE = 6'h00;
   localparam logic [5:0] CFG_BOOT_TRIM = 6'h01;
   localparam logic [5:0] CFG_FAULT_LO = 6'h28;
   localparam logic [5:0] CFG_FAULT_HI = 6'h29;
   localparam logic [5:0] CFG_CLOCK_THR_LOW = 6'h20;
   localparam logic [5:0] CFG_CLOCK_THR_HIGH = 6'h21;
   localparam logic [5:0] CFG_TRIM_A = 6'h22;
   localparam logic [5:0] CFG_TRIM_B = 6'h23;
   localparam logic [5:0] CFG_TRIM_C = 6'h24;
   localparam logic [5:0] CFG_LOOP_FIXED_LO = 6'h25;
   localparam logic [5:0] CFG_LOOP_FIXED_HI = 6'h26;
   localparam logic [5:0] CFG_ALARM_LOW_TRIG = 6'h1A;
   localparam logic [5:0] CFG_ALARM_LOW_OUT = 6'h1B;
   localparam logic [5:0] CFG_ALARM_HIGH_TRIG = 6'h1C;
   localparam logic [5:0] CFG_ALARM_HIGH_OUT = 6'h1D;
   localparam logic [5:0] CFG_STEER_LVL0 = 6'h1C;
   localparam logic [5:0] CFG_STEER_LVL1 = 6'h1D;
   localparam logic [5:0] CFG_STEER_LVL2 = 6'h1E;
   localparam int MODE_CHECK = 7;
   localparam int MODE_DIGITAL = 6;
   localparam int MODE_LIMIT = 5;
   localparam int MODE_STEER = 4;
   localparam int MODE_TURBO = 3;
   localparam int MODE_VOUT = 2;
   localparam int MODE_EXT_TEMP = 1;
   localparam int MODE_LOOP = 0;
   localparam int CORE_CLK_HZ = 250000000;
   localparam int BAUD_DEFAULT = 9600;
   localparam int CFG_BYTES = 48;
   localparam int RAM_BYTES = 64;
   typedef enum {
      ST_INIT, ST_SUM, ST_LOAD, ST_IDLE, ST_SEND, ST_WAIT_TX, ST_WAIT_DATA,
      ST_STORE, ST_RESET
   } scu_state_t;
endpackage
`default_nettype wire

// ---- scu_sensor_config_uart_command_props.sv ----
// port checker for the serial configuration command interpreter
// assumes one core clock, synchronous high reset, bit time of 8 cycles or more
`default_nettype none
module scu_sensor_config_uart_command_props
   import scu_pkg::*;
#(
   parameter int BAUD = BAUD_DEFAULT,
   parameter int CLK_HZ = CORE_CLK_HZ
)(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // watched outputs
   input wire logic serialTx,
   input wire logic [7:0] operating_mode_config,
   input wire logic checksumFault,
   input wire logic digital_output_override,
   input wire logic [7:0] overrideLevel,
   input wire logic loopFixedActive,
   input wire logic general_pin_one_oe_n,
   input wire logic general_pin_two_oe_n,
   input wire logic voltage_output_enable,
   input wire logic current_loop_output_enable,
   input wire logic turboEnable,
   input wire logic externalTempSelect
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----
   // sequences
   // ----
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   // eight cycles only: any tx bit lasts a whole bit time, which is no shorter
   sequence startHeld;
      (!serialTx) [*8];
   endsequence
   sequence idleHeld;
      serialTx [*8];
   endsequence
   // ----
   // assertions
   // ----
   tx_idle_a: assert property ($fell(reset) |-> idleHeld)
      else $error("tx not idle after reset");
   start_bit_a: assert property ($fell(serialTx) |-> startHeld)
      else $error("tx low level shorter than a bit");
   mode_pins_a: assert property ({turboEnable, voltage_output_enable, externalTempSelect,
      current_loop_output_enable} == operating_mode_config[3:0])
      else $error("mode pins differ from mode byte");
   loop_fixed_a: assert property (loopFixedActive == (voltage_output_enable
      && current_loop_output_enable && operating_mode_config[MODE_DIGITAL]))
      else $error("loop fixed value enable wrong");
   pin_enable_a: assert property ((general_pin_one_oe_n == !operating_mode_config[MODE_STEER])
      && (general_pin_two_oe_n == !operating_mode_config[MODE_STEER]))
      else $error("general pin enables wrong");
   override_cause_a: assert property (digital_output_override |->
      operating_mode_config[MODE_LIMIT] && !operating_mode_config[MODE_STEER])
      else $error("override without limiting");
   override_level_a: assert property (!digital_output_override |-> overrideLevel == 8'h00)
      else $error("override level without override");
   fault_cause_a: assert property ($rose(checksumFault) |-> ##[0:2]
      operating_mode_config[MODE_CHECK])
      else $error("checksum fault while check disabled");
endmodule
bind scu_sensor_config_uart_command scu_sensor_config_uart_command_props
   #(.BAUD(BAUD), .CLK_HZ(CLK_HZ)) props (.core_clk(core_clk), .reset(reset),
   .serialTx(serialTx), .operating_mode_config(operating_mode_config),
   .checksumFault(checksumFault), .digital_output_override(digital_output_override),
   .overrideLevel(overrideLevel), .loopFixedActive(loopFixedActive),
   .general_pin_one_oe_n(general_pin_one_oe_n), .general_pin_two_oe_n(general_pin_two_oe_n),
   .voltage_output_enable(voltage_output_enable), .turboEnable(turboEnable),
   .current_loop_output_enable(current_loop_output_enable),
   .externalTempSelect(externalTempSelect));
`default_nettype wire

// ---- scu_host_model.sv ----
// host side of the serial link: sends and receives 8N1 bytes
// assumes callers start at a falling edge; line idles high between frames
`default_nettype none
module scu_host_model #(
   parameter int BT = 16
)(
   input wire logic core_clk,
   input wire logic serialTx,
   output logic serialRx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial serialRx = 1'b1;
   // returns mid stop bit, so a prompt reply start is not missed
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(negedge core_clk);
      for (int i = 0; i < 10; i++)
      begin
         serialRx = f[i];
         repeat ((i == 9) ? BT / 2 : BT) @(negedge core_clk);
      end
   endtask
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      while (serialTx !== 1'b0 && n < 30 * BT)
      begin
         @(negedge core_clk);
         n++;
      end
      ok = (serialTx === 1'b0);
      if (ok)
      begin
         repeat (BT / 2) @(negedge core_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BT) @(negedge core_clk);
            b[i] = serialTx;
         end
         repeat (BT) @(negedge core_clk);
         ok = (serialTx === 1'b1);
         repeat (BT / 2) @(negedge core_clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- sensor_config_uart_command_tb.sv ----
// self-checking bench for the command interpreter, driven through the host model
// assumes a shortened bit time of 16 cycles
`default_nettype none
module sensor_config_uart_command_tb;
   import scu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BT = 16;
   logic core_clk = 1'b0;
   logic reset, serialRx, serialTx, checksumFault, digital_output_override, loopFixedActive;
   logic [9:0] temperatureReading;
   logic [15:0] sampledInput;
   logic [7:0] operating_mode_config, oscillatorTrim, overrideLevel;
   logic [11:0] faultValue, loopFixedValue;
   logic pinOneOut, pinTwoOut, pinOneOen, pinTwoOen, vOut, loopOut, turbo, extTemp;
   int failCount = 0;
   int testsRun = 0;
   always #2 core_clk = ~core_clk;
   scu_sensor_config_uart_command #(.BAUD(10), .CLK_HZ(160)) uut (.core_clk(core_clk),
      .reset(reset), .serialRx(serialRx), .serialTx(serialTx),
      .temperatureReading(temperatureReading), .sampledInput(sampledInput),
      .operating_mode_config(operating_mode_config), .oscillatorTrim(oscillatorTrim),
      .checksumFault(checksumFault), .faultValue(faultValue),
      .digital_output_override(digital_output_override), .overrideLevel(overrideLevel),
      .loopFixedActive(loopFixedActive), .loopFixedValue(loopFixedValue),
      .general_pin_one_in(1'b0), .general_pin_two_in(1'b0),
      .general_pin_one_out(pinOneOut), .general_pin_two_out(pinTwoOut),
      .general_pin_one_oe_n(pinOneOen), .general_pin_two_oe_n(pinTwoOen),
      .voltage_output_enable(vOut), .current_loop_output_enable(loopOut),
      .turboEnable(turbo), .externalTempSelect(extTemp));
   scu_host_model #(.BT(BT)) host (.core_clk(core_clk), .serialTx(serialTx),
      .serialRx(serialRx));
   // ----
   // helpers
   // ----
   task automatic stopTest();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      testsRun++;
      if (got !== exp)
      begin
         failCount++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   function automatic logic [7:0] cfgVal(input int i);
      case (i)
         0: return 8'hD7;
         1: return 8'h5A;
         26: return 8'h20;
         27: return 8'h05;
         28: return 8'h40;
         29: return 8'h80;
         30: return 8'hC0;
         32: return 8'h40;
         33: return 8'h80;
         34: return 8'h11;
         35: return 8'h22;
         36: return 8'h33;
         37: return 8'hA5;
         38: return 8'h03;
         40: return 8'h3C;
         41: return 8'h0E;
         default: return 8'h00;
      endcase
   endfunction
   task automatic waitTrim(input logic [7:0] e);
      int n;
      n = 0;
      while (oscillatorTrim !== e && n < 200)
      begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic cmdRead(input logic [1:0] op, input logic [5:0] a, input logic [7:0] e);
      logic [7:0] b;
      logic ok;
      host.send({op, a});
      host.recv(b, ok);
      chk("read reply", {8'h01, e}, {7'h00, ok, b});
   endtask
   task automatic cmdWrite(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
      logic [7:0] b;
      logic ok;
      host.send({op, a});
      host.recv(b, ok);
      chk("echo", {8'h01, op, a}, {7'h00, ok, b});
      host.send(d);
      repeat (2)
      begin
         host.recv(b, ok);
         chk("ack", {8'h01, ACK_BYTE}, {7'h00, ok, b});
      end
   endtask
   // boot trim shows only while init runs, before the range trim takes over
   task automatic softReset();
      cmdRead(OP_CFG_RD, CFG_RESET_ADDR, ACK_BYTE);
      waitTrim(8'h5A);
      chk("boot trim", 16'h005A, 16'(oscillatorTrim));
      repeat (80) @(negedge core_clk);
   endtask
   // ----
   // scenarios
   // ----
   task automatic testLoad();
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < 47; i++)
      begin
         cmdWrite(OP_CFG_WR, 6'(i), cfgVal(i));
         sum = sum + cfgVal(i);
      end
      cmdWrite(OP_CFG_WR, CFG_LAST, CHECKSUM_TARGET - sum);
      sampledInput = 16'h5000;
      softReset();
      chk("steer pins", 16'h0002, {14'h0000, pinOneOut, pinTwoOut});
      chk("mode", 16'h00D7, 16'(operating_mode_config));
      chk("mode pins", 16'h0007, {12'h000, turbo, vOut, extTemp, loopOut});
      chk("loop fixed", 16'h13A5, {3'h0, loopFixedActive, loopFixedValue});
      chk("fault", 16'h0E3C, {3'h0, checksumFault, faultValue});
      chk("pin enables", 16'h0000, {14'h0000, pinOneOen, pinTwoOen});
      $display("test load done");
   endtask
   task automatic testReads();
      logic [7:0] b;
      logic ok;
      cmdRead(OP_CFG_RD, CFG_MODE, 8'hD7);
      cmdRead(OP_CFG_RD, CFG_LOOP_FIXED_LO, 8'hA5);
      cmdWrite(OP_RAM_WR, 6'h3F, 8'h69);
      cmdRead(OP_RAM_RD, 6'h3F, 8'h69);
      host.send({OP_CFG_RD, 6'h30});
      host.recv(b, ok);
      chk("no reply", 16'h0000, 16'(ok));
      softReset();
      cmdRead(OP_RAM_RD, 6'h3F, 8'h00);
      $display("test reads done");
   endtask
   task automatic testTrim();
      logic [9:0] tv [4] = '{10'h0FC, 10'h100, 10'h1FC, 10'h200};
      logic [7:0] ex [4] = '{8'h11, 8'h22, 8'h22, 8'h33};
      for (int i = 0; i < 4; i++)
      begin
         temperatureReading = tv[i];
         waitTrim(ex[i]);
         chk("range trim", 16'(ex[i]), 16'(oscillatorTrim));
      end
      $display("test trim done");
   endtask
   task automatic testDeferred();
      logic [15:0] si [3] = '{16'h1000, 16'h3000, 16'h5000};
      logic [8:0] ex [3] = '{9'h105, 9'h000, 9'h180};
      int n;
      cmdWrite(OP_CFG_WR, CFG_MODE, 8'h67);
      chk("mode held", 16'h00D7, 16'(operating_mode_config));
      softReset();
      chk("mode new", 16'h0067, {7'h00, checksumFault, operating_mode_config});
      chk("pins released", 16'h0003, {14'h0000, pinOneOen, pinTwoOen});
      for (int i = 0; i < 3; i++)
      begin
         sampledInput = si[i];
         n = 0;
         while ({digital_output_override, overrideLevel} !== ex[i] && n < 20)
         begin
            @(negedge core_clk);
            n++;
         end
         chk("limit", 16'(ex[i]), {7'h00, digital_output_override, overrideLevel});
      end
      $display("test deferred done");
   endtask
   task automatic testChecksum();
      cmdWrite(OP_CFG_WR, 6'h02, 8'h01);
      cmdWrite(OP_CFG_WR, CFG_MODE, 8'hD7);
      softReset();
      chk("fault set", 16'h1E3C, {3'h0, checksumFault, faultValue});
      $display("test checksum done");
   endtask
   // ----
   // sequence and watchdog
   // ----
   initial
   begin
      reset = 1'b1;
      temperatureReading = 10'h000;
      sampledInput = 16'h3000;
      repeat (10) @(negedge core_clk);
      chk("reset state", 16'h0001, {14'h0000, checksumFault, serialTx});
      reset = 1'b0;
      repeat (80) @(negedge core_clk);
      testLoad();
      testReads();
      testTrim();
      testDeferred();
      testChecksum();
      stopTest();
   end
   initial
   begin
      repeat (95000) @(posedge core_clk);
      failCount++;
      stopTest();
   end
endmodule
`default_nettype wire
